// *** logic/channel_trim_volume.v ***
`timescale 1ns/100ps
`include "channel_trim_volume_regs.vh"

module channel_trim_volume (
   input  wire        clock,
   input  wire        srst,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [7:0]  reg_rdata,
   output wire [3:0]  ch3_gain_trim_code,
   output wire [7:0]  ch3_phase_delay_cycles,
   output wire [7:0]  ch4_volume_code,
   input  wire        mod_tick,
   input  wire        ch3_mod_bit,
   output reg         ch3_mod_out,
   input  wire [23:0] ch3_sample_in,
   input  wire        ch3_sample_valid,
   output reg  [23:0] ch3_sample_out,
   output reg         ch3_sample_out_valid,
   input  wire [23:0] ch4_sample_in,
   input  wire        ch4_sample_valid,
   output reg  [23:0] ch4_sample_out,
   output reg         ch4_sample_out_valid
);

   // ==========================================
   // Register file
   reg [3:0] gain_trim;
   reg [7:0] phase_delay;
   reg [7:0] volume;

   assign ch3_gain_trim_code     = gain_trim;
   assign ch3_phase_delay_cycles = phase_delay;
   assign ch4_volume_code        = volume;

   // ==========================================
   // Address decode
   // One decoder serves both the write and the read path, so the two can
   // never disagree about which register an address selects.
   localparam SEL_NONE  = 2'h0;
   localparam SEL_GAIN  = 2'h1;
   localparam SEL_PHASE = 2'h2;
   localparam SEL_VOL   = 2'h3;

   function [1:0] reg_select;
      input [7:0] addr;
      begin
         case (addr)
            `CH3_GAIN_TRIM_ADDR:      reg_select = SEL_GAIN;
            `CH3_PHASE_DELAY_ADDR:    reg_select = SEL_PHASE;
            `CH4_DIGITAL_VOLUME_ADDR: reg_select = SEL_VOL;
            default:                  reg_select = SEL_NONE;
         endcase
      end
   endfunction

   wire [1:0] sel;

   assign sel = reg_select(reg_addr);

   always @(posedge clock) begin
      if (srst) begin
         gain_trim   <= `CH3_GAIN_TRIM_CODE_RST;
         phase_delay <= `CH3_PHASE_DELAY_RESET;
         volume      <= `CH4_VOLUME_RESET;
         reg_rdata   <= 8'h00;
      end else begin
         if (reg_write) begin
            case (sel)
               // Only the upper nibble is stored; the low nibble is reserved.
               SEL_GAIN:
                  gain_trim <= reg_wdata[`GAIN_TRIM_MSB:`GAIN_TRIM_LSB];
               SEL_PHASE: phase_delay <= reg_wdata;
               SEL_VOL:   volume <= reg_wdata;
               default: ;
            endcase
         end
         // A read in the same cycle as a write returns the old value, since
         // both paths see the registers as they stood before the edge.
         if (reg_read) begin
            case (sel)
               SEL_GAIN:  reg_rdata <= {gain_trim, 4'h0};
               SEL_PHASE: reg_rdata <= phase_delay;
               SEL_VOL:   reg_rdata <= volume;
               default:   reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ==========================================
   // Phase delay on the channel 3 modulator stream
   // A full shift register costs area, but every delay setting is served
   // at once and a new setting needs no pointer to be realigned.
   reg [`PHASE_DEPTH-1:0] history;

   always @(posedge clock) begin
      if (srst) begin
         history     <= {`PHASE_DEPTH{1'b0}};
         ch3_mod_out <= 1'b0;
      end else if (mod_tick) begin
         history <= {history[`PHASE_DEPTH-2:0], ch3_mod_bit};
         if (phase_delay == 8'h00)
            ch3_mod_out <= ch3_mod_bit;
         else
            ch3_mod_out <= history[phase_delay - 8'h01];
      end
   end

   // ==========================================
   // Coefficient tables and saturation
   function [15:0] trim_coef;
      input [3:0] code;
      begin
         case (code)
            4'h0: trim_coef = 16'h3A5E;
            4'h1: trim_coef = 16'h3B0C;
            4'h2: trim_coef = 16'h3BBA;
            4'h3: trim_coef = 16'h3C6C;
            4'h4: trim_coef = 16'h3D1E;
            4'h5: trim_coef = 16'h3DD4;
            4'h6: trim_coef = 16'h3E8B;
            4'h7: trim_coef = 16'h3F44;
            4'h8: trim_coef = 16'h4000;
            4'h9: trim_coef = 16'h40BE;
            4'hA: trim_coef = 16'h417E;
            4'hB: trim_coef = 16'h4240;
            4'hC: trim_coef = 16'h4304;
            4'hD: trim_coef = 16'h43CB;
            4'hE: trim_coef = 16'h4494;
            default: trim_coef = 16'h455F;
         endcase
      end
   endfunction

   // Half-dB mantissas for one octave. Using an octave as twelve steps
   // trades about 0.02 dB per octave of accuracy for a tiny table.
   function [15:0] vol_mant;
      input [3:0] r;
      begin
         case (r)
            4'h0: vol_mant = 16'h4000;
            4'h1: vol_mant = 16'h43CB;
            4'h2: vol_mant = 16'h47CF;
            4'h3: vol_mant = 16'h4C11;
            4'h4: vol_mant = 16'h5092;
            4'h5: vol_mant = 16'h5558;
            4'h6: vol_mant = 16'h5A67;
            4'h7: vol_mant = 16'h5FC2;
            4'h8: vol_mant = 16'h656F;
            4'h9: vol_mant = 16'h6B71;
            4'hA: vol_mant = 16'h71CF;
            default: vol_mant = 16'h788E;
         endcase
      end
   endfunction

   // Saturating instead of wrapping keeps an overdriven channel from
   // flipping sign at full scale.
   function [23:0] sat24;
      input signed [63:0] v;
      begin
         if (v > 64'sh00000000007FFFFF)
            sat24 = 24'h7FFFFF;
         else if (v < -64'sh0000000000800000)
            sat24 = 24'h800000;
         else
            sat24 = v[23:0];
      end
   endfunction

   // ==========================================
   // Channel 3 gain trim
   wire signed [63:0] ch3_prod;
   wire signed [63:0] ch3_scaled;

   assign ch3_prod   = $signed(ch3_sample_in) * $signed({1'b0, trim_coef(gain_trim)});
   assign ch3_scaled = ch3_prod >>> `COEF_FRAC;

   always @(posedge clock) begin
      if (srst) begin
         ch3_sample_out       <= 24'h000000;
         ch3_sample_out_valid <= 1'b0;
      end else begin
         ch3_sample_out_valid <= ch3_sample_valid;
         if (ch3_sample_valid)
            ch3_sample_out <= sat24(ch3_scaled);
      end
   end

   // ==========================================
   // Channel 4 digital volume
   // The offset keeps the octave index positive: code 201 lands on 17.
   wire [8:0]         vol_biased;
   wire [8:0]         vol_octave;
   wire [8:0]         vol_step;
   wire signed [63:0] ch4_prod;
   wire signed [63:0] ch4_scaled;

   assign vol_biased = {1'b0, volume} + `VOL_OFFSET - `VOL_UNITY_CODE;
   assign vol_octave = vol_biased / `VOL_STEPS_PER_OCTAVE;
   assign vol_step   = vol_biased % `VOL_STEPS_PER_OCTAVE;
   assign ch4_prod   = $signed(ch4_sample_in) * $signed({1'b0, vol_mant(vol_step[3:0])});
   assign ch4_scaled = (ch4_prod <<< vol_octave) >>> `VOL_SHIFT_BASE;

   always @(posedge clock) begin
      if (srst) begin
         ch4_sample_out       <= 24'h000000;
         ch4_sample_out_valid <= 1'b0;
      end else begin
         ch4_sample_out_valid <= ch4_sample_valid;
         if (ch4_sample_valid) begin
            if (volume == 8'h00)
               ch4_sample_out <= 24'h000000;
            else
               ch4_sample_out <= sat24(ch4_scaled);
         end
      end
   end

endmodule

// *** logic/channel_trim_volume_regs.vh ***
`ifndef CHANNEL_TRIM_VOLUME_REGS_VH
`define CHANNEL_TRIM_VOLUME_REGS_VH

// ==========================================
// Register offsets
`define CH3_GAIN_TRIM_ADDR      8'h49
`define CH3_PHASE_DELAY_ADDR    8'h4A
`define CH4_DIGITAL_VOLUME_ADDR 8'h4D

// ==========================================
// Reset values and fields
`define CH3_GAIN_TRIM_RESET     8'h80
`define CH3_GAIN_TRIM_CODE_RST  4'h8
`define CH3_PHASE_DELAY_RESET   8'h00
`define CH4_VOLUME_RESET        8'hC9
`define GAIN_TRIM_MSB           7
`define GAIN_TRIM_LSB           4

// ==========================================
// Arithmetic constants
`define SAMPLE_W                24
`define COEF_FRAC               14
`define VOL_OFFSET              9'h0CC
`define VOL_UNITY_CODE          9'h0C9
`define VOL_STEPS_PER_OCTAVE    9'h00C
`define VOL_SHIFT_BASE          31
`define PHASE_DEPTH             255

`endif

// *** bench/channel_trim_volume_chk.sv ***
`timescale 1ns/100ps
module channel_trim_volume_chk (
   input wire        clock,
   input wire        srst,
   input wire [7:0]  reg_addr,
   input wire [7:0]  reg_wdata,
   input wire        reg_write,
   input wire        reg_read,
   input wire [7:0]  reg_rdata,
   input wire [3:0]  ch3_gain_trim_code,
   input wire [7:0]  ch3_phase_delay_cycles,
   input wire [7:0]  ch4_volume_code,
   input wire        ch4_sample_valid,
   input wire [23:0] ch4_sample_out,
   input wire        ch4_sample_out_valid
);
   // ==========================================
   // Checks.
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence gain_rd;
      reg_read && reg_addr == 8'h49;
   endsequence
   gain_reset_a: assert property (
      $past(srst) |-> ch3_gain_trim_code == 4'h8) else $error("gain trim reset wrong");
   phase_reset_a: assert property (
      $past(srst) |-> ch3_phase_delay_cycles == 8'h00) else $error("phase reset wrong");
   vol_reset_a: assert property (
      $past(srst) |-> ch4_volume_code == 8'hC9) else $error("volume reset wrong");
   gain_write_a: assert property (
      reg_write && reg_addr == 8'h49 |=> {4'h0, ch3_gain_trim_code} == $past(reg_wdata) >> 4)
      else $error("gain trim write lost");
   phase_write_a: assert property (
      reg_write && reg_addr == 8'h4A |=> ch3_phase_delay_cycles == $past(reg_wdata))
      else $error("phase write lost");
   vol_write_a: assert property (
      reg_write && reg_addr == 8'h4D |=> ch4_volume_code == $past(reg_wdata))
      else $error("volume write lost");
   reserved_zero_a: assert property (
      gain_rd |=> reg_rdata[3:0] == 4'h0) else $error("reserved bits not zero");
   volume_mute_a: assert property (
      ch4_sample_valid && ch4_volume_code == 8'h00 |=> ch4_sample_out_valid
      && ch4_sample_out == 24'h000000) else $error("mute leaks signal");
endmodule
bind channel_trim_volume channel_trim_volume_chk i_chk (.clock(clock), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .ch3_gain_trim_code(ch3_gain_trim_code),
   .ch3_phase_delay_cycles(ch3_phase_delay_cycles), .ch4_volume_code(ch4_volume_code),
   .ch4_sample_valid(ch4_sample_valid), .ch4_sample_out(ch4_sample_out),
   .ch4_sample_out_valid(ch4_sample_out_valid));

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
   reg         clock = 1'h0;
   reg         srst = 1'h1;
   reg  [7:0]  addr = 8'h00;
   reg  [7:0]  wdata = 8'h00;
   reg         wr_en = 1'h0;
   reg         rd_en = 1'h0;
   reg         tick = 1'h0;
   reg         mbit = 1'h0;
   reg         valid = 1'h0;
   reg  [39:0] codes = 40'h0001C9D5FF;
   reg  [23:0] sample = 24'h100000;
   wire [7:0]  rdata;
   wire        mout;
   wire [23:0] out3;
   wire [23:0] out4;
   wire        v3;
   wire        v4;
   integer     fails = 0;
   integer     comparisons = 0;
   integer     i;
   integer     c;
   real        e;
   always #50 clock = ~clock;
   channel_trim_volume i_channel_trim_volume (.clock(clock), .srst(srst), .reg_addr(addr),
      .reg_wdata(wdata), .reg_write(wr_en), .reg_read(rd_en), .reg_rdata(rdata),
      .ch3_gain_trim_code(), .ch3_phase_delay_cycles(), .ch4_volume_code(), .mod_tick(tick),
      .ch3_mod_bit(mbit), .ch3_mod_out(mout), .ch3_sample_in(sample),
      .ch3_sample_valid(valid), .ch3_sample_out(out3), .ch3_sample_out_valid(v3),
      .ch4_sample_in(sample), .ch4_sample_valid(valid), .ch4_sample_out(out4),
      .ch4_sample_out_valid(v4));
   // ==========================================
   // Helpers.
   task stop_test;
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Scaled outputs are compared within a tolerance, since the gain curve is approximated.
   task chk(input string n, input real x, input [23:0] g, input real t);
      comparisons = comparisons + 1;
      if (^g === 1'bx || $itor($signed(g)) - x > t || x - $itor($signed(g)) > t) begin
         fails = fails + 1;
         $display("Error %0s expected %0.1f seen %h", n, x, g);
      end
   endtask
   // Strobes are {write, read, tick, valid}; every strobe lasts exactly one cycle.
   task cyc(input [3:0] s, input [7:0] a, input [7:0] d);
      @(negedge clock);
      {wr_en, rd_en, tick, valid, addr, wdata} = {s, a, d};
      @(negedge clock);
      {wr_en, rd_en, tick, valid} = 4'h0;
   endtask
   // ==========================================
   // Scenarios.
   task t_reset;
      cyc(4'h4, 8'h49, 8'h00);
      chk("gain", 128.0, rdata, 0.0);
      cyc(4'h4, 8'h4A, 8'h00);
      chk("phase", 0.0, rdata, 0.0);
      cyc(4'h4, 8'h4D, 8'h00);
      chk("volume", 201.0, rdata, 0.0);
      cyc(4'h4, 8'h4B, 8'h00);
      chk("unmapped", 0.0, rdata, 0.0);
   endtask
   task t_gain;
      for (c = 0; c < 16; c = c + 5) begin
         cyc(4'h8, 8'h49, {c[3:0], 4'h0});
         cyc(4'h4, 8'h49, 8'h00);
         chk("gain", c * 16, rdata, 0.0);
         cyc(4'h1, 8'h00, 8'h00);
         chk("ch3_out", 1048576.0 * 10.0 ** ((c - 8) / 200.0), out3, 3000.0);
         chk("ch3_valid", 1.0, v3, 0.0);
      end
   endtask
   task t_volume;
      for (i = 0; i < 5; i = i + 1) begin
         c = codes[39 - 8 * i -: 8];
         cyc(4'h8, 8'h4D, c[7:0]);
         cyc(4'h1, 8'h00, 8'h00);
         e = (c == 0) ? 0.0 : 1048576.0 * 10.0 ** ((c - 201) / 40.0);
         if (e > 8388607.0)
            e = 8388607.0;
         chk("ch4_out", e, out4, e * 0.003 + 2.0);
         chk("ch4_valid", 1.0, v4, 0.0);
      end
      sample = 24'hF00000;
      cyc(4'h1, 8'h00, 8'h00);
      chk("ch4_sat", -8388608.0, out4, 0.0);
      chk("ch3_neg", -1048576.0 * 10.0 ** (7 / 200.0), out3, 3000.0);
      sample = 24'h100000;
      cyc(4'h4, 8'h4D, 8'h00);
      chk("volume", 255.0, rdata, 0.0);
   endtask
   task t_phase(input [7:0] n);
      cyc(4'h8, 8'h4A, n);
      for (i = 0; i < 300; i = i + 1) begin
         mbit = i[0] ^ i[3] ^ i[6];
         cyc(4'h2, 8'h00, 8'h00);
         c = i - n;
         if (i >= n)
            chk("mod_out", c[0] ^ c[3] ^ c[6], mout, 0.0);
      end
   endtask
   task t_rereset;
      @(negedge clock);
      srst = 1'h1;
      repeat (2) @(negedge clock);
      srst = 1'h0;
      t_reset;
   endtask
   initial begin
      repeat (5) @(negedge clock);
      srst = 1'h0;
      t_reset;
      t_gain;
      t_volume;
      t_phase(8'h00);
      t_phase(8'h03);
      t_phase(8'hFF);
      t_rereset;
      stop_test;
   end
endmodule
